// ### common/keypad_pkg.sv
package keypad_pkg;

	// Clock and timing
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int SCAN_PERIOD_MS = 10;
	localparam int SCAN_PERIOD_CYCLES = SCAN_PERIOD_MS * 1000000 / CLOCK_PERIOD_NS;
	localparam int ROW_SETTLE_NS = 100;
	localparam int ROW_SETTLE_CYCLES = (ROW_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int TIMER_WIDTH = 20;

	// Matrix geometry and scancode layout
	localparam int MATRIX_LINES = 8;
	localparam int ROW_STRIDE = 8;
	localparam logic [7:0] RELEASE_OFFSET = 8'h80;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFFSET_CONTROL = 8'h00;
	localparam logic [7:0] OFFSET_DEBOUNCE = 8'h04;
	localparam logic [7:0] OFFSET_GPIO_DIR = 8'h08;
	localparam logic [7:0] OFFSET_GPIO_OUT = 8'h0c;
	localparam logic [7:0] OFFSET_GPIO_IN = 8'h10;
	localparam logic [7:0] OFFSET_EVENT = 8'h14;
	localparam logic [7:0] OFFSET_INT_STATUS = 8'h18;
	localparam logic [7:0] OFFSET_INT_ENABLE = 8'h1c;
	localparam logic [7:0] OFFSET_INT_CLEAR = 8'h20;
	localparam logic [7:0] OFFSET_SCAN_STATE = 8'h24;

	// Control fields
	localparam int CTRL_ROWS_LSB = 0;
	localparam int CTRL_COLS_LSB = 4;
	localparam int CTRL_ENABLE_BIT = 8;
	localparam int CTRL_LOW_POWER_BIT = 9;
	localparam logic [3:0] ROWS_RESET = 4'h8;
	localparam logic [3:0] COLS_RESET = 4'h8;
	localparam logic [3:0] DEBOUNCE_RESET = 4'h3;

	// Event register fields
	localparam int EVENT_VALUE_BIT = 8;
	localparam int EVENT_VALID_BIT = 31;

	// Interrupt status bits
	localparam int INT_DETECT_BIT = 0;
	localparam int INT_EVENT_BIT = 1;
	localparam int INT_BITS = 2;

	typedef enum logic [1:0] {
		PHASE_IDLE,
		PHASE_SCAN,
		PHASE_COMPARE,
		PHASE_WAIT
	} scan_phase_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic write;
		logic read;
	} bus_request_type;

	typedef struct packed {
		logic [7:0] col;
		logic [7:0] row;
	} pin_group_type;

endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
	import keypad_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input pin_group_type pins,
	output pin_group_type synced
);

	typedef struct packed {
		logic [15:0] first;
		logic [15:0] second;
		logic [15:0] third;
		logic [15:0] agreed;
	} sync_state_type;

	sync_state_type st;
	sync_state_type next_st;
	logic [15:0] next_agreed;

	// A change counts only once the second and third stage agree
	for (genvar i = 0; i < 16; i++)
	begin : agree_bit
		assign next_agreed[i] = (st.second[i] == st.third[i]) ? st.third[i] : st.agreed[i];
	end

	always_comb
	begin
		next_st = st;
		next_st.first = pins;
		next_st.second = st.first;
		next_st.third = st.second;
		next_st.agreed = next_agreed;
	end

	// Idle level of pulled-up lines is high, so reset to ones
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			st <= {4{16'hffff}};
		else
			st <= next_st;
	end

	assign synced = st.agreed;

endmodule

// ### hw/keypad_matrix_scanner.sv
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// [RULE_01] Scan up to eight rows by eight columns
// [RULE_02] Unused row and column pins act as GPIO
// [RULE_03] Run mode and low-power mode both detect presses
// [RULE_04] Low-power wake works without the clock
// [RULE_05] Key down interrupts, then full scan follows
// [RULE_06] Rescan every 10 ms while keys active
// [RULE_07] Every change debounced, delay is configurable
// [RULE_08] Press code is row times 8 plus column
// [RULE_09] Release code is press code plus 128
// [RULE_10] Event value 1 press, 0 release
// [RULE_11] Active row and column counts configurable
// [RULE_12] Report after state stable configured scan count
module keypad_matrix_scanner
	import keypad_pkg::*;
#(
	parameter int SCAN_PERIOD_CYCLES_P = SCAN_PERIOD_CYCLES
)
(
	input wire logic clock,
	input wire logic rst_n,
	input bus_request_type bus,
	output logic [31:0] read_data,
	input pin_group_type pin_in,
	output pin_group_type pin_out,
	output pin_group_type pin_oe,
	output logic irq,
	output logic key_wake
);

	localparam logic [TIMER_WIDTH-1:0] SCAN_RELOAD = TIMER_WIDTH'(SCAN_PERIOD_CYCLES_P - 1);
	localparam logic [TIMER_WIDTH-1:0] SETTLE_RELOAD = TIMER_WIDTH'(ROW_SETTLE_CYCLES - 1);

	typedef struct packed {
		logic [3:0] row_count;
		logic [3:0] col_count;
		logic enable;
		logic low_power;
		logic [3:0] debounce_scan_interval;
		pin_group_type gpio_dir;
		pin_group_type gpio_out;
		logic [INT_BITS-1:0] int_status;
		logic [INT_BITS-1:0] int_enable;
		logic event_valid;
		logic [7:0] event_code;
		logic event_value;
		scan_phase_type phase;
		logic [TIMER_WIDTH-1:0] timer;
		logic [2:0] row;
		logic [5:0] key;
		logic [7:0][7:0] raw;
		logic [7:0][7:0] reported;
		logic [63:0][3:0] stable_count;
		logic [31:0] read_data;
		pin_group_type pin_out;
		pin_group_type pin_oe;
	} scanner_state_type;

	scanner_state_type st;
	scanner_state_type next_st;
	logic [1:0] rst_pipe;
	logic rst_n_sync;
	pin_group_type synced;
	logic [7:0] row_active;
	logic [7:0] col_active;
	logic [7:0] col_pressed;
	logic sampled;
	logic [4:0] count_plus;
	logic any_active;

	// Reset release through two flops
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n_sync = rst_pipe[1];

	pin_sync u_pin_sync (
		.clock(clock),
		.rst_n(rst_n_sync),
		.pins(pin_in),
		.synced(synced)
	);

	// Lines below the configured counts belong to the matrix
	for (genvar i = 0; i < MATRIX_LINES; i++)
	begin : line_mask
		assign row_active[i] = (4'(i) < st.row_count); // [RULE_11]
		assign col_active[i] = (4'(i) < st.col_count); // [RULE_11]
	end

	assign col_pressed = ~synced.col & col_active; // [RULE_01]

	// Unclocked path: rows stay driven low while idle, so a press pulls a column low
	assign key_wake = st.enable & st.low_power & (|(~pin_in.col & col_active)); // [RULE_04]

	always_comb
	begin
		next_st = st;
		sampled = st.raw[st.key[5:3]][st.key[2:0]];
		count_plus = {1'b0, st.stable_count[st.key]} + 5'h01;
		any_active = (|st.raw) | (|st.reported);
		next_st.read_data = 32'h0;

		if (bus.write)
		begin
			case (bus.addr)
				OFFSET_CONTROL:
				begin
					next_st.row_count = bus.wdata[CTRL_ROWS_LSB +: 4];
					next_st.col_count = bus.wdata[CTRL_COLS_LSB +: 4];
					next_st.enable = bus.wdata[CTRL_ENABLE_BIT];
					next_st.low_power = bus.wdata[CTRL_LOW_POWER_BIT];
				end
				OFFSET_DEBOUNCE: next_st.debounce_scan_interval = bus.wdata[3:0]; // [RULE_07]
				OFFSET_GPIO_DIR: next_st.gpio_dir = bus.wdata[15:0];
				OFFSET_GPIO_OUT: next_st.gpio_out = bus.wdata[15:0];
				OFFSET_INT_ENABLE: next_st.int_enable = bus.wdata[INT_BITS-1:0];
				OFFSET_INT_CLEAR: next_st.int_status = st.int_status & ~bus.wdata[INT_BITS-1:0];
				default: ;
			endcase
		end

		if (bus.read)
		begin
			case (bus.addr)
				OFFSET_CONTROL:
				begin
					next_st.read_data[CTRL_ROWS_LSB +: 4] = st.row_count;
					next_st.read_data[CTRL_COLS_LSB +: 4] = st.col_count;
					next_st.read_data[CTRL_ENABLE_BIT] = st.enable;
					next_st.read_data[CTRL_LOW_POWER_BIT] = st.low_power;
				end
				OFFSET_DEBOUNCE: next_st.read_data[3:0] = st.debounce_scan_interval;
				OFFSET_GPIO_DIR: next_st.read_data[15:0] = st.gpio_dir;
				OFFSET_GPIO_OUT: next_st.read_data[15:0] = st.gpio_out;
				OFFSET_GPIO_IN: next_st.read_data[15:0] = synced;
				OFFSET_EVENT:
				begin
					next_st.read_data[7:0] = st.event_code;
					next_st.read_data[EVENT_VALUE_BIT] = st.event_value;
					next_st.read_data[EVENT_VALID_BIT] = st.event_valid;
					// Reading the event frees the holding register
					next_st.event_valid = 1'b0;
				end
				OFFSET_INT_STATUS: next_st.read_data[INT_BITS-1:0] = st.int_status;
				OFFSET_INT_ENABLE: next_st.read_data[INT_BITS-1:0] = st.int_enable;
				OFFSET_SCAN_STATE:
				begin
					next_st.read_data[1:0] = st.phase;
					next_st.read_data[15:8] = st.reported[0] | st.reported[1] | st.reported[2]
						| st.reported[3] | st.reported[4] | st.reported[5] | st.reported[6]
						| st.reported[7];
				end
				default: ;
			endcase
		end

		// Scan sequencer; hardware sets below the clear so a set wins
		case (st.phase)
			PHASE_IDLE:
			begin
				if (st.enable && (|col_pressed)) // [RULE_03]
				begin
					next_st.int_status[INT_DETECT_BIT] = 1'b1; // [RULE_05]
					next_st.phase = PHASE_SCAN; // [RULE_05]
					next_st.row = 3'h0;
					next_st.timer = SETTLE_RELOAD;
				end
			end
			PHASE_SCAN:
			begin
				if (st.timer != '0)
					next_st.timer = st.timer - 1'b1;
				else
				begin
					next_st.raw[st.row] = col_pressed & {8{row_active[st.row]}}; // [RULE_01]
					if ({1'b0, st.row} + 4'h1 >= st.row_count || st.row == 3'h7) // [RULE_11]
					begin
						next_st.phase = PHASE_COMPARE;
						next_st.key = 6'h0;
					end
					else
					begin
						next_st.row = st.row + 3'h1;
						next_st.timer = SETTLE_RELOAD;
					end
				end
			end
			PHASE_COMPARE:
			begin
				if (sampled == st.reported[st.key[5:3]][st.key[2:0]])
				begin
					next_st.stable_count[st.key] = 4'h0;
					next_st.key = st.key + 6'h1;
				end
				else if (count_plus >= {1'b0, st.debounce_scan_interval}) // [RULE_12]
				begin
					// Holds here until software has taken the previous event
					if (!st.event_valid)
					begin
						next_st.reported[st.key[5:3]][st.key[2:0]] = sampled; // [RULE_07]
						next_st.stable_count[st.key] = 4'h0;
						next_st.event_code = {2'b00, st.key} | (sampled ? 8'h00 : RELEASE_OFFSET); // [RULE_08] [RULE_09]
						next_st.event_value = sampled; // [RULE_10]
						next_st.event_valid = 1'b1;
						next_st.int_status[INT_EVENT_BIT] = 1'b1;
						next_st.key = st.key + 6'h1;
					end
				end
				else
				begin
					next_st.stable_count[st.key] = count_plus[3:0]; // [RULE_12]
					next_st.key = st.key + 6'h1;
				end
				if (st.key == 6'h3f && next_st.key == 6'h0)
				begin
					if (any_active)
					begin
						next_st.phase = PHASE_WAIT; // [RULE_06]
						next_st.timer = SCAN_RELOAD;
					end
					else
						next_st.phase = PHASE_IDLE;
				end
			end
			PHASE_WAIT:
			begin
				if (st.timer != '0)
					next_st.timer = st.timer - 1'b1;
				else
				begin
					next_st.phase = PHASE_SCAN; // [RULE_06]
					next_st.row = 3'h0;
					next_st.timer = SETTLE_RELOAD;
				end
			end
			default: next_st.phase = PHASE_IDLE;
		endcase

		if (!st.enable)
			next_st.phase = PHASE_IDLE;

		// Pin ownership: matrix rows drive low (during a scan only the scanned row), matrix columns are inputs, the rest follow the GPIO registers
		for (int i = 0; i < MATRIX_LINES; i++)
		begin
			if (row_active[i] && st.enable)
			begin
				next_st.pin_out.row[i] = 1'b0;
				next_st.pin_oe.row[i] = (next_st.phase == PHASE_SCAN) ? (next_st.row == 3'(i)) : 1'b1;
			end
			else
			begin
				next_st.pin_out.row[i] = st.gpio_out.row[i]; // [RULE_02]
				next_st.pin_oe.row[i] = st.gpio_dir.row[i]; // [RULE_02]
			end
			if (col_active[i] && st.enable)
			begin
				next_st.pin_out.col[i] = 1'b0;
				next_st.pin_oe.col[i] = 1'b0;
			end
			else
			begin
				next_st.pin_out.col[i] = st.gpio_out.col[i]; // [RULE_02]
				next_st.pin_oe.col[i] = st.gpio_dir.col[i]; // [RULE_02]
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			st <= '0;
			st.row_count <= ROWS_RESET;
			st.col_count <= COLS_RESET;
			st.debounce_scan_interval <= DEBOUNCE_RESET;
			st.phase <= PHASE_IDLE;
		end
		else
			st <= next_st;
	end

	assign read_data = st.read_data;
	assign pin_out = st.pin_out;
	assign pin_oe = st.pin_oe;
	assign irq = |(st.int_status & st.int_enable);

	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n_sync);

	scan_row_single_a: assert property ( // [RULE_01]
		(st.phase == PHASE_SCAN && st.timer == '0 && st.enable && row_active[st.row])
		|-> ($onehot(st.pin_oe.row & row_active) && st.pin_oe.row[st.row]))
		else $error("more than one matrix row driven while sampling");

	gpio_row_pass_a: assert property ( // [RULE_02]
		(!row_active[7] && $past(!row_active[7]))
		|-> (st.pin_oe.row[7] == $past(st.gpio_dir.row[7])
			&& st.pin_out.row[7] == $past(st.gpio_out.row[7])))
		else $error("spare row pin does not follow its GPIO setting");

	disabled_idle_a: assert property ( // [RULE_03]
		!st.enable |=> st.phase == PHASE_IDLE)
		else $error("scanner active while disabled");

	wake_press_a: assert property ( // [RULE_04]
		(st.enable && st.low_power && st.phase == PHASE_IDLE && (|(~pin_in.col & col_active)))
		|-> key_wake)
		else $error("press in low-power mode gives no wake");

	detect_start_a: assert property ( // [RULE_05]
		(st.phase == PHASE_IDLE && st.enable && (|col_pressed))
		|=> (st.int_status[INT_DETECT_BIT] && st.phase == PHASE_SCAN && st.row == 3'h0))
		else $error("key down did not flag and start a scan");

	rescan_start_a: assert property ( // [RULE_06]
		(st.phase == PHASE_WAIT && st.timer == '0 && st.enable)
		|=> (st.phase == PHASE_SCAN && st.row == 3'h0 && st.timer == SETTLE_RELOAD))
		else $error("periodic rescan did not start");

	debounce_hold_a: assert property ( // [RULE_07] [RULE_12]
		(st.phase == PHASE_COMPARE && !st.event_valid
			&& sampled != st.reported[st.key[5:3]][st.key[2:0]])
		|=> (st.event_valid == ($past(count_plus) >= {1'b0, $past(st.debounce_scan_interval)})))
		else $error("key change reported before its stable count");

	press_code_a: assert property ( // [RULE_08]
		$rose(st.event_valid)
		|-> ({1'b0, st.event_code[5:3]} < st.row_count && {1'b0, st.event_code[2:0]} < st.col_count))
		else $error("scancode outside the active matrix");

	release_code_a: assert property ( // [RULE_09]
		st.event_valid |-> (st.event_code[7] == !st.event_value && !st.event_code[6]))
		else $error("release flag does not match event value");

	event_value_a: assert property ( // [RULE_10]
		$rose(st.event_valid)
		|-> st.event_value == st.reported[st.event_code[5:3]][st.event_code[2:0]])
		else $error("event value differs from debounced key state");

	column_limit_a: assert property ( // [RULE_11]
		(st.phase == PHASE_SCAN && st.timer == '0)
		|=> ((st.raw[$past(st.row)] & ~col_active) == 8'h00))
		else $error("sample taken from an unassigned column");

endmodule

// ### dv/keypad_switch_matrix.sv
`timescale 1ns/1ps
module keypad_switch_matrix
	import keypad_pkg::*;
(
	input pin_group_type pin_out,
	input pin_group_type pin_oe,
	input wire logic [63:0] keys,
	output pin_group_type pin_in
);
	// Undriven lines rest at the pull-up level; a closed key pulls its column to a low row
	always_comb
	begin
		for (int r = 0; r < 8; r++)
			pin_in.row[r] = pin_oe.row[r] ? pin_out.row[r] : 1'b1;
		for (int c = 0; c < 8; c++)
		begin
			pin_in.col[c] = pin_oe.col[c] ? pin_out.col[c] : 1'b1;
			for (int r = 0; r < 8; r++)
				if (keys[r * 8 + c] && !pin_in.row[r] && !pin_oe.col[c])
					pin_in.col[c] = 1'b0;
		end
	end
endmodule

// ### dv/tb_keypad_matrix_scanner.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
	begin \
		check_count++; \
		if ((gt) !== (ex)) \
		begin \
			n_mismatch++; \
			$display("mismatch %s exp %h got %h", nm, ex, gt); \
		end \
	end
module tb_keypad_matrix_scanner
	import keypad_pkg::*;
;
	localparam int SP = 50;
	logic clock = 1'b0;
	logic clk_run = 1'b1;
	logic rst_n;
	bus_request_type bus;
	logic [31:0] read_data;
	pin_group_type pin_in;
	pin_group_type pin_out;
	pin_group_type pin_oe;
	logic irq;
	logic key_wake;
	logic [63:0] keys;
	int n_mismatch = 0;
	int check_count = 0;
	int c1;
	int c3;

	always #5 if (clk_run) clock = ~clock;

	keypad_matrix_scanner #(.SCAN_PERIOD_CYCLES_P(SP)) u_keypad_matrix_scanner (
		.clock(clock), .rst_n(rst_n), .bus(bus), .read_data(read_data), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .key_wake(key_wake));
	keypad_switch_matrix u_keypad_switch_matrix (
		.pin_out(pin_out), .pin_oe(pin_oe), .keys(keys), .pin_in(pin_in));

	task automatic test_done;
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		bus <= '{addr: a, wdata: v, write: 1'b1, read: 1'b0};
		@(posedge clock);
		bus.write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		bus <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
		@(posedge clock);
		bus.read <= 1'b0;
		#1 v = read_data;
	endtask

	// Polls the event register, bounded so a lost event cannot hang the run
	task automatic wait_event(output logic [31:0] v, output int n);
		n = 0;
		v = '0;
		while (v[EVENT_VALID_BIT] !== 1'b1 && n < 2000)
		begin
			rd(OFFSET_EVENT, v);
			n += 2;
		end
	endtask

	task automatic press_release(input int row, input int col, input int dbn, input logic ei,
		output int cyc);
		logic [7:0] code;
		logic [31:0] v;
		int n;
		code = 8'(row * ROW_STRIDE + col);
		// Detection only starts from idle, so let any rescan loop run out first
		v = 32'h1;
		n = 0;
		while (v[1:0] !== 2'h0 && n < 2000)
		begin
			rd(OFFSET_SCAN_STATE, v);
			n += 2;
		end
		`CHK("scanner idle", 2'h0, v[1:0])
		wr(OFFSET_DEBOUNCE, 32'(dbn));
		wr(OFFSET_INT_CLEAR, 32'h3);
		keys[code[5:0]] <= 1'b1;
		wait_event(v, cyc);
		`CHK("press event", {1'b1, 22'h0, 1'b1, code}, v)
		rd(OFFSET_SCAN_STATE, v);
		`CHK("held column", 8'(1 << col), v[15:8])
		`CHK("detect irq", ei, irq)
		keys[code[5:0]] <= 1'b0;
		wait_event(v, n);
		`CHK("release event", {1'b1, 22'h0, 1'b0, code | RELEASE_OFFSET}, v)
	endtask

	task automatic reset_values;
		logic [31:0] v;
		rd(OFFSET_CONTROL, v);
		`CHK("control reset", 32'h00000088, v)
		rd(OFFSET_DEBOUNCE, v);
		`CHK("debounce reset", 32'h00000003, v)
		rd(8'hfc, v);
		`CHK("unmapped read", 32'h0, v)
		rd(OFFSET_SCAN_STATE, v);
		`CHK("scan state reset", 32'h0, v)
		`CHK("irq reset", 1'b0, irq)
	endtask

	task automatic key_scan;
		wr(OFFSET_CONTROL, 32'h00000188);
		wr(OFFSET_INT_ENABLE, 32'h1);
		press_release(0, 1, 1, 1'b1, c1);
		press_release(7, 7, 1, 1'b1, c3);
		press_release(2, 3, 3, 1'b1, c3);
		`CHK("debounce delay", 1'b1, c3 > c1 + 2 * SP)
	endtask

	task automatic irq_mask;
		logic [31:0] v;
		wr(OFFSET_INT_ENABLE, 32'h0);
		press_release(3, 2, 1, 1'b0, c1);
		rd(OFFSET_INT_STATUS, v);
		`CHK("sticky status", 32'h3, v)
		wr(OFFSET_INT_STATUS, 32'h0);
		wr(OFFSET_INT_ENABLE, 32'h2);
		#1 `CHK("irq enabled", 1'b1, irq)
		wr(OFFSET_INT_CLEAR, 32'h3);
		#1 `CHK("irq cleared", 1'b0, irq)
		rd(OFFSET_INT_STATUS, v);
		`CHK("status cleared", 32'h0, v)
	endtask

	task automatic gpio_pins;
		logic [31:0] v;
		wr(OFFSET_CONTROL, 32'h00000144);
		wr(OFFSET_GPIO_DIR, 32'h80);
		wr(OFFSET_GPIO_OUT, 32'h0);
		repeat (5) @(posedge clock);
		`CHK("row oe", 8'h8f, pin_oe.row)
		`CHK("col oe", 8'h00, pin_oe.col)
		rd(OFFSET_GPIO_IN, v);
		`CHK("gpio in low", 32'h0000ff70, v)
		wr(OFFSET_GPIO_OUT, 32'h00008080);
		repeat (5) @(posedge clock);
		`CHK("row out", 8'h80, pin_out.row)
		`CHK("col out", 8'h80, pin_out.col)
		rd(OFFSET_GPIO_IN, v);
		`CHK("gpio in high", 32'h0000fff0, v)
	endtask

	task automatic low_power;
		wr(OFFSET_GPIO_DIR, 32'h0);
		wr(OFFSET_CONTROL, 32'h00000388);
		repeat (4) @(posedge clock);
		// Wake must come through with the clock halted
		clk_run = 1'b0;
		#20 keys[9] = 1'b1;
		#20 `CHK("wake on press", 1'b1, key_wake)
		keys[9] = 1'b0;
		#20 `CHK("wake released", 1'b0, key_wake)
		clk_run = 1'b1;
	endtask

	initial
	begin
		bus = '0;
		keys = '0;
		rst_n = 1'b0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		reset_values;
		key_scan;
		irq_mask;
		gpio_pins;
		low_power;
		test_done;
	end

	initial
	begin
		// A clean run takes a little over two thousand cycles; the limit of 40000 cycles is over fifteen times that
		#400000;
		n_mismatch++;
		test_done;
	end
endmodule
